// ===== design/nbrx_pkg.sv
package nbrx_pkg;

	// Serial modes, as held in the mode field
	localparam logic [1:0] MODE_SHIFT = 2'h0;
	localparam logic [1:0] MODE_8BIT  = 2'h1;
	localparam logic [1:0] MODE_9BIT2 = 2'h2;
	localparam logic [1:0] MODE_9BIT3 = 2'h3;

	// Register byte addresses
	localparam logic [4:0] ADDR_CTRL   = 5'h00;
	localparam logic [4:0] ADDR_STATUS = 5'h04;
	localparam logic [4:0] ADDR_DATA   = 5'h08;
	localparam logic [4:0] ADDR_SLAVE_ADDR_REG  = 5'h0c;
	localparam logic [4:0] ADDR_SMASK  = 5'h10;
	localparam logic [4:0] ADDR_IMASK  = 5'h14;

	// Control register fields
	localparam int CTRL_EN_BIT     = 0;
	localparam int CTRL_FILT_BIT   = 1;
	localparam int CTRL_MODE_LSB   = 2;
	localparam int CTRL_DIV_LSB    = 8;

	// Status register fields
	localparam int STAT_DONE_BIT   = 0;
	localparam int STAT_NINTH_BIT  = 1;
	localparam int STAT_LOST_BIT   = 2;
	localparam int STAT_FALSE_BIT  = 3;

	// Reset values
	localparam logic [7:0]  SLAVE_ADDR_REG_RST   = 8'h00;
	localparam logic [7:0]  SMASK_RST   = 8'h00;
	localparam logic [15:0] DIV_RST     = 16'h0000;
	localparam logic [3:0]  IMASK_RST   = 4'h0;

	// Bit timing: sixteen sample states per bit
	localparam logic [3:0] SAMPLE_A    = 4'h6;
	localparam logic [3:0] SAMPLE_B    = 4'h7;
	localparam logic [3:0] SAMPLE_C    = 4'h8;
	localparam logic [3:0] STATE_LAST  = 4'hf;
	localparam logic [8:0] SHIFT_PRESET = 9'h1ff;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_HUNT  = 2'b00,
		ST_RECV  = 2'b01,
		ST_TAIL  = 2'b11
	} nbrx_state_t;

endpackage : nbrx_pkg

// ===== design/nbrx_rx.sv
// Summary of operation
// R1 - Nine-bit shift register, final shift then load
// R2 - Load only if flag clear, filter ok
// R3 - Failed conditions discard the whole frame
// R4 - Ninth bit and byte stored, flag set
// R5 - Hunt for falling edge one bit later
// R6 - Nonzero start sample restarts the hunt
// R7 - Filtering: interrupt only for ninth bit one
// R8 - Master marks addresses with ninth bit one
// R9 - Filtering ignored in shift mode
// R10 - 8-bit mode filtering needs valid stop
// R11 - 9-bit filtering needs address match too
// R12 - Given match only where mask is one
// R13 - Broadcast is address OR mask, zeros ignored
// R14 - Reset clears address and mask registers
// R15 - Address checked at final shift
// R16 - Sixteen states, majority of 7/8/9
// R17 - Frame: start, eight LSB-first, ninth, stop
// R18 - Start edge resets counter, presets ones
`timescale 1ns/10ps
module nbrx_rx
	import nbrx_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	input  wire logic        rxd_i,
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             irq_o
);

	typedef struct packed {
		logic [1:0]  rxd_sync;
		logic        rxd_prev;
		nbrx_state_t state;
		logic [8:0]  shreg;
		logic        first;
		logic [15:0] div_cnt;
		logic        tick;
		logic        enable;
		logic        multiproc_filter_en;
		logic [1:0]  mode;
		logic [15:0] div;
		logic [7:0]  serial_buffer;
		logic        rx_ninth_bit;
		logic        rx_done_flag;
		logic        lost;
		logic        false_start;
		logic [3:0]  imask;
		logic [7:0]  slave_addr_reg;
		logic [7:0]  slave_addr_mask;
		logic        aw_held;
		logic [4:0]  aw_addr;
		logic        w_held;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        aw_rdy;
		logic        w_rdy;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        irq;
	} nbrx_st_t;

	nbrx_st_t st_ff;
	nbrx_st_t nxt_st;
	logic [1:0] rst_sync_ff;
	logic     rst_n_sync;
	logic     restart;
	logic     bit_end;
	logic     bit_val;

	// Given and broadcast comparison, don't-care where the qualifier is zero
	function automatic logic addr_hit(input logic [7:0] rx, input logic [7:0] adr,
		input logic [7:0] msk);
		logic given;
		logic bcast;
		given = (((rx ^ adr) & msk) == 8'h00); // R12
		bcast = (((~rx) & (adr | msk)) == 8'h00); // R13
		addr_hit = given | bcast;
	endfunction : addr_hit

	function automatic logic is_addr(input logic [4:0] a, input logic [4:0] r);
		is_addr = (a == r);
	endfunction : is_addr

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n_sync = rst_sync_ff[1];

	nbrx_sample u_sample (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_sync),
		.tick_i    (st_ff.tick),
		.restart_i (restart),
		.rxd_i     (st_ff.rxd_sync[1]),
		.bit_end_o (bit_end),
		.bit_val_o (bit_val)
	);

	// Falling edge seen while hunting starts a frame
	assign restart = st_ff.enable && (st_ff.state == ST_HUNT) && st_ff.tick
		&& st_ff.rxd_prev && !st_ff.rxd_sync[1]; // R5

	always_comb begin
		logic        ninth;
		logic        ok;
		logic        filt;
		logic [31:0] rd;
		logic        wr_go;
		logic [3:0]  w1c;
		logic [3:0]  set_ev;
		set_ev = 4'h0;
		ninth  = 1'b0;
		ok     = 1'b0;
		filt   = 1'b0;
		rd     = 32'h0000_0000;
		wr_go  = 1'b0;
		w1c    = 4'h0;
		nxt_st = st_ff;
		nxt_st.rxd_sync = {st_ff.rxd_sync[0], rxd_i};
		// Divider gives the 16x sample enable
		nxt_st.tick = 1'b0;
		if (st_ff.div_cnt >= st_ff.div) begin
			nxt_st.div_cnt = 16'h0000;
			nxt_st.tick    = 1'b1;
		end else begin
			nxt_st.div_cnt = st_ff.div_cnt + 16'h0001;
		end
		if (st_ff.tick) nxt_st.rxd_prev = st_ff.rxd_sync[1];

		// Receiver
		unique case (st_ff.state)
			ST_HUNT: begin
				if (restart) begin
					nxt_st.shreg = SHIFT_PRESET; // R18
					nxt_st.first = 1'b1;
					nxt_st.state = ST_RECV;
				end
			end
			ST_RECV: begin
				if (bit_end) begin
					nxt_st.first = 1'b0;
					if (st_ff.first && bit_val) begin
						nxt_st.false_start = 1'b1;
						set_ev[STAT_FALSE_BIT] = 1'b1;
						nxt_st.state       = ST_HUNT; // R6
					end else if (!st_ff.shreg[0]) begin
						// Start bit at the far stage: this is the final shift
						ninth = bit_val; // R17
						filt  = st_ff.multiproc_filter_en && (st_ff.mode != MODE_SHIFT); // R9
						if (st_ff.mode == MODE_8BIT) begin
							ok = !filt || ninth; // R10
						end else begin
							ok = !filt || (ninth && addr_hit(st_ff.shreg[8:1],
								st_ff.slave_addr_reg, st_ff.slave_addr_mask)); // R11 R15 R7
						end
						if (!st_ff.rx_done_flag && ok) begin // R2
							nxt_st.serial_buffer = st_ff.shreg[8:1]; // R4
							nxt_st.rx_ninth_bit  = ninth; // R4
							nxt_st.rx_done_flag  = 1'b1; // R4
						end else begin
							nxt_st.lost = 1'b1; // R3
							set_ev[STAT_LOST_BIT] = 1'b1;
						end
						nxt_st.state = ST_TAIL;
					end else begin
						// LSB first, bits enter at the top so bit 0 lands lowest
						nxt_st.shreg = {bit_val, st_ff.shreg[8:1]}; // R1 R17
					end
				end
			end
			ST_TAIL: begin
				if (bit_end) nxt_st.state = ST_HUNT; // R5
			end
			default: nxt_st.state = ST_HUNT;
		endcase
		if (!st_ff.enable) nxt_st.state = ST_HUNT;

		// Bus write side, address and data in either order
		if (s_axi_awvalid && !st_ff.aw_held) begin
			nxt_st.aw_held = 1'b1;
			nxt_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_ff.w_held) begin
			nxt_st.w_held = 1'b1;
			nxt_st.w_data = s_axi_wdata;
			nxt_st.w_strb = s_axi_wstrb;
		end
		wr_go = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
		if (wr_go) begin
			nxt_st.aw_held = 1'b0;
			nxt_st.w_held  = 1'b0;
			nxt_st.bvalid  = 1'b1;
			nxt_st.bresp   = RESP_OKAY;
			if (is_addr(st_ff.aw_addr, ADDR_CTRL)) begin
				if (st_ff.w_strb[0]) begin
					nxt_st.enable              = st_ff.w_data[CTRL_EN_BIT];
					nxt_st.multiproc_filter_en = st_ff.w_data[CTRL_FILT_BIT];
					nxt_st.mode = st_ff.w_data[CTRL_MODE_LSB +: 2];
				end
				if (st_ff.w_strb[1]) nxt_st.div[7:0] = st_ff.w_data[CTRL_DIV_LSB +: 8];
				if (st_ff.w_strb[2]) nxt_st.div[15:8] = st_ff.w_data[CTRL_DIV_LSB + 8 +: 8];
			end else if (is_addr(st_ff.aw_addr, ADDR_STATUS)) begin
				if (st_ff.w_strb[0]) w1c = st_ff.w_data[3:0];
			end else if (is_addr(st_ff.aw_addr, ADDR_SLAVE_ADDR_REG)) begin
				if (st_ff.w_strb[0]) nxt_st.slave_addr_reg = st_ff.w_data[7:0];
			end else if (is_addr(st_ff.aw_addr, ADDR_SMASK)) begin
				if (st_ff.w_strb[0]) nxt_st.slave_addr_mask = st_ff.w_data[7:0];
			end else if (is_addr(st_ff.aw_addr, ADDR_IMASK)) begin
				if (st_ff.w_strb[0]) nxt_st.imask = st_ff.w_data[3:0];
			end else if (!is_addr(st_ff.aw_addr, ADDR_DATA)) begin
				nxt_st.bresp = RESP_SLVERR;
			end
		end
		if (st_ff.bvalid && s_axi_bready) nxt_st.bvalid = 1'b0;
		// A same-cycle set beats the clear, except on an already set done flag
		if (w1c[STAT_DONE_BIT] && !(nxt_st.rx_done_flag && !st_ff.rx_done_flag))
			nxt_st.rx_done_flag = 1'b0;
		if (w1c[STAT_LOST_BIT] && !set_ev[STAT_LOST_BIT])
			nxt_st.lost = 1'b0;
		if (w1c[STAT_FALSE_BIT] && !set_ev[STAT_FALSE_BIT])
			nxt_st.false_start = 1'b0;
		// Ready is a registered "not holding" flag
		nxt_st.aw_rdy = !nxt_st.aw_held;
		nxt_st.w_rdy  = !nxt_st.w_held;

		// Bus read side
		nxt_st.arready = 1'b0;
		if (s_axi_arvalid && !st_ff.arready && !st_ff.rvalid) begin
			nxt_st.arready = 1'b1;
			nxt_st.rvalid  = 1'b1;
			nxt_st.rresp   = RESP_OKAY;
			if (is_addr(s_axi_araddr, ADDR_CTRL)) begin
				rd[CTRL_EN_BIT]             = st_ff.enable;
				rd[CTRL_FILT_BIT]           = st_ff.multiproc_filter_en;
				rd[CTRL_MODE_LSB +: 2]      = st_ff.mode;
				rd[CTRL_DIV_LSB +: 16]      = st_ff.div;
			end else if (is_addr(s_axi_araddr, ADDR_STATUS)) begin
				rd[STAT_DONE_BIT]  = st_ff.rx_done_flag;
				rd[STAT_NINTH_BIT] = st_ff.rx_ninth_bit;
				rd[STAT_LOST_BIT]  = st_ff.lost;
				rd[STAT_FALSE_BIT] = st_ff.false_start;
			end else if (is_addr(s_axi_araddr, ADDR_DATA)) begin
				rd[7:0] = st_ff.serial_buffer;
				rd[8]   = st_ff.rx_ninth_bit;
			end else if (is_addr(s_axi_araddr, ADDR_SLAVE_ADDR_REG)) begin
				rd[7:0] = st_ff.slave_addr_reg;
			end else if (is_addr(s_axi_araddr, ADDR_SMASK)) begin
				rd[7:0] = st_ff.slave_addr_mask;
			end else if (is_addr(s_axi_araddr, ADDR_IMASK)) begin
				rd[3:0] = st_ff.imask;
			end else begin
				nxt_st.rresp = RESP_SLVERR;
			end
			nxt_st.rdata = rd;
		end
		if (st_ff.rvalid && s_axi_rready) nxt_st.rvalid = 1'b0;

		// Level interrupt from unmasked sticky bits
		nxt_st.irq = |({nxt_st.false_start, nxt_st.lost, 1'b0, nxt_st.rx_done_flag}
			& nxt_st.imask); // R7
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			st_ff.rxd_sync            <= 2'h3;
			st_ff.rxd_prev            <= 1'b1;
			st_ff.state               <= ST_HUNT;
			st_ff.shreg               <= SHIFT_PRESET;
			st_ff.first               <= 1'b0;
			st_ff.div_cnt             <= 16'h0000;
			st_ff.tick                <= 1'b0;
			st_ff.enable              <= 1'b0;
			st_ff.multiproc_filter_en <= 1'b0;
			st_ff.mode                <= MODE_SHIFT;
			st_ff.div                 <= DIV_RST;
			st_ff.serial_buffer       <= 8'h00;
			st_ff.rx_ninth_bit        <= 1'b0;
			st_ff.rx_done_flag        <= 1'b0;
			st_ff.lost                <= 1'b0;
			st_ff.false_start         <= 1'b0;
			st_ff.imask               <= IMASK_RST;
			st_ff.slave_addr_reg      <= SLAVE_ADDR_REG_RST; // R14
			st_ff.slave_addr_mask     <= SMASK_RST; // R14
			st_ff.aw_held             <= 1'b0;
			st_ff.aw_addr             <= 5'h00;
			st_ff.w_held              <= 1'b0;
			st_ff.w_data              <= 32'h0000_0000;
			st_ff.w_strb              <= 4'h0;
			st_ff.aw_rdy              <= 1'b0;
			st_ff.w_rdy               <= 1'b0;
			st_ff.bvalid              <= 1'b0;
			st_ff.bresp               <= RESP_OKAY;
			st_ff.arready             <= 1'b0;
			st_ff.rvalid              <= 1'b0;
			st_ff.rdata               <= 32'h0000_0000;
			st_ff.rresp               <= RESP_OKAY;
			st_ff.irq                 <= 1'b0;
		end else begin
			st_ff.rxd_sync            <= nxt_st.rxd_sync;
			st_ff.rxd_prev            <= nxt_st.rxd_prev;
			st_ff.state               <= nxt_st.state;
			st_ff.shreg               <= nxt_st.shreg;
			st_ff.first               <= nxt_st.first;
			st_ff.div_cnt             <= nxt_st.div_cnt;
			st_ff.tick                <= nxt_st.tick;
			st_ff.enable              <= nxt_st.enable;
			st_ff.multiproc_filter_en <= nxt_st.multiproc_filter_en;
			st_ff.mode                <= nxt_st.mode;
			st_ff.div                 <= nxt_st.div;
			st_ff.serial_buffer       <= nxt_st.serial_buffer;
			st_ff.rx_ninth_bit        <= nxt_st.rx_ninth_bit;
			st_ff.rx_done_flag        <= nxt_st.rx_done_flag;
			st_ff.lost                <= nxt_st.lost;
			st_ff.false_start         <= nxt_st.false_start;
			st_ff.imask               <= nxt_st.imask;
			st_ff.slave_addr_reg      <= nxt_st.slave_addr_reg;
			st_ff.slave_addr_mask     <= nxt_st.slave_addr_mask;
			st_ff.aw_held             <= nxt_st.aw_held;
			st_ff.aw_addr             <= nxt_st.aw_addr;
			st_ff.w_held              <= nxt_st.w_held;
			st_ff.w_data              <= nxt_st.w_data;
			st_ff.w_strb              <= nxt_st.w_strb;
			st_ff.aw_rdy              <= nxt_st.aw_rdy;
			st_ff.w_rdy               <= nxt_st.w_rdy;
			st_ff.bvalid              <= nxt_st.bvalid;
			st_ff.bresp               <= nxt_st.bresp;
			st_ff.arready             <= nxt_st.arready;
			st_ff.rvalid              <= nxt_st.rvalid;
			st_ff.rdata               <= nxt_st.rdata;
			st_ff.rresp               <= nxt_st.rresp;
			st_ff.irq                 <= nxt_st.irq;
		end
	end

	assign s_axi_awready = st_ff.aw_rdy;
	assign s_axi_wready  = st_ff.w_rdy;
	assign s_axi_bvalid  = st_ff.bvalid;
	assign s_axi_bresp   = st_ff.bresp;
	assign s_axi_arready = st_ff.arready;
	assign s_axi_rvalid  = st_ff.rvalid;
	assign s_axi_rdata   = st_ff.rdata;
	assign s_axi_rresp   = st_ff.rresp;
	assign irq_o         = st_ff.irq;

endmodule : nbrx_rx

// ===== design/nbrx_sample.sv
`timescale 1ns/10ps
module nbrx_sample
	import nbrx_pkg::*;
(
	input  wire logic       clk_sys_i,
	input  wire logic       rst_n_i,
	input  wire logic       tick_i,
	input  wire logic       restart_i,
	input  wire logic       rxd_i,
	output logic            bit_end_o,
	output logic            bit_val_o
);

	typedef struct packed {
		logic [3:0] phase;
		logic [2:0] smp;
		logic       val;
		logic       done;
	} nbrx_smp_st_t;

	nbrx_smp_st_t st_ff;
	nbrx_smp_st_t nxt_st;

	always_comb begin
		nxt_st      = st_ff;
		nxt_st.done = 1'b0;
		if (restart_i) begin
			nxt_st.phase = 4'h0; // R18
			nxt_st.smp   = 3'h0;
		end else if (tick_i) begin
			nxt_st.phase = st_ff.phase + 4'h1;
			if (st_ff.phase == SAMPLE_A) nxt_st.smp[0] = rxd_i; // R16
			if (st_ff.phase == SAMPLE_B) nxt_st.smp[1] = rxd_i; // R16
			if (st_ff.phase == SAMPLE_C) begin
				nxt_st.smp[2] = rxd_i; // R16
				// Majority of three rejects single-sample glitches
				nxt_st.val = (st_ff.smp[0] & st_ff.smp[1]) | (st_ff.smp[0] & rxd_i)
					| (st_ff.smp[1] & rxd_i); // R16
			end
			if (st_ff.phase == STATE_LAST) nxt_st.done = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign bit_end_o = st_ff.done;
	assign bit_val_o = st_ff.val;

endmodule : nbrx_sample

// ===== verif/nbrx_master_model.sv
`timescale 1ns/10ps
module nbrx_master_model #(
	parameter int BIT_CLKS = 16
) (
	input  wire logic clk_sys_i,
	output logic      txd_o
);
	// Line idles high between frames
	initial txd_o = 1'b1;

	task automatic send_frame(input logic [8:0] frame);
		logic [10:0] bits;
		bits = {1'b1, frame, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(posedge clk_sys_i);
			txd_o <= bits[i];
			repeat (BIT_CLKS - 1) @(posedge clk_sys_i);
		end
	endtask : send_frame

	// Short low pulse, too brief to pass as a start bit
	task automatic glitch(input int clks);
		@(posedge clk_sys_i);
		txd_o <= 1'b0;
		repeat (clks) @(posedge clk_sys_i);
		txd_o <= 1'b1;
	endtask : glitch
endmodule : nbrx_master_model

// ===== verif/nbrx_rx_assertions.sv
`timescale 1ns/10ps
module nbrx_rx_chk
	import nbrx_pkg::*;
(
	input wire logic        clk_sys_i,
	input wire logic        rst_n_i,
	input wire logic        rxd_i,
	input wire logic [4:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [4:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        irq_o
);
	sequence both_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence b_answer;
		##[1:3] s_axi_bvalid;
	endsequence
	sequence ar_taken;
		s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
	endsequence

	write_answer_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		both_taken |-> b_answer) else $error("write response missing");
	read_answer_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		ar_taken |=> s_axi_arready && s_axi_rvalid) else $error("read response late");
	arready_pulse_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_axi_arready |=> !s_axi_arready) else $error("arready longer than one cycle");
	rdata_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
		&& $stable(s_axi_rresp)) else $error("read data not held");
	bresp_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	b_release_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
	aw_release_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("awready stuck");
	w_release_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_axi_wvalid && s_axi_wready |=> !s_axi_wready) else $error("wready stuck");
	resp_legal_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_axi_rvalid |-> s_axi_rresp == RESP_OKAY || s_axi_rresp == RESP_SLVERR)
		else $error("illegal read response");
	// No disable here: the reset itself is the cause
	reset_quiet_a: assert property (@(posedge clk_sys_i)
		!rst_n_i |-> !irq_o && !s_axi_bvalid && !s_axi_rvalid) else $error("output live in reset");
endmodule : nbrx_rx_chk

bind nbrx_rx nbrx_rx_chk nbrx_rx_chk_inst (.clk_sys_i, .rst_n_i, .rxd_i, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_o);

// ===== verif/nbrx_rx_tb.sv
`timescale 1ns/10ps
module nbrx_rx_tb
	import nbrx_pkg::*;
;
	typedef struct packed {
		logic [7:0] sa;
		logic [7:0] mk;
		logic [1:0] md;
		logic [8:0] fr;
		logic       ok;
	} nbrx_case_t;

	logic        clk_sys_i     = 1'b0;
	logic        rst_n_i       = 1'b1;
	wire logic   rxd_i;
	logic [4:0]  s_axi_awaddr  = 5'h00;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata   = 32'h0;
	logic [3:0]  s_axi_wstrb   = 4'hf;
	logic        s_axi_wvalid  = 1'b0;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready  = 1'b0;
	logic [4:0]  s_axi_araddr  = 5'h00;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready  = 1'b0;
	logic        irq_o;
	int          miscompares   = 0;
	int          check_count   = 0;

	nbrx_case_t cases [9] = '{
		'{8'h00, 8'h00, 2'h3, 9'h100, 1'b1}, '{8'hc0, 8'hfd, 2'h2, 9'h0c2, 1'b0},
		'{8'hc0, 8'hfd, 2'h2, 9'h1c2, 1'b1}, '{8'hc0, 8'hfd, 2'h2, 9'h1c1, 1'b0},
		'{8'hc0, 8'hfd, 2'h2, 9'h1ff, 1'b1}, '{8'hc0, 8'hfd, 2'h3, 9'h1fc, 1'b0},
		'{8'hc0, 8'hfd, 2'h1, 9'h05a, 1'b0}, '{8'hc0, 8'hfd, 2'h1, 9'h15a, 1'b1},
		'{8'hc0, 8'hfd, 2'h0, 9'h05a, 1'b1}};
	logic [4:0] rst_regs [4] = '{ADDR_CTRL, ADDR_SLAVE_ADDR_REG, ADDR_SMASK, ADDR_IMASK};

	always #50 clk_sys_i = ~clk_sys_i;

	nbrx_rx nbrx_rx_inst (.clk_sys_i, .rst_n_i, .rxd_i, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_o);
	nbrx_master_model #(.BIT_CLKS(16)) nbrx_master_model_inst (.clk_sys_i, .txd_o(rxd_i));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge clk_sys_i);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge clk_sys_i);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	// Stop bit plus sync delay before looking at status
	task automatic rx(input logic [8:0] f);
		nbrx_master_model_inst.send_frame(f);
		repeat (8) @(posedge clk_sys_i);
	endtask : rx

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict

	initial begin
		repeat (30000) @(posedge clk_sys_i);
		miscompares++;
		give_verdict();
	end

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		// Real falling edge at time zero so the reset takes hold before any edge
		rst_n_i <= 1'b0;
		repeat (12) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		foreach (rst_regs[i]) begin
			rd(rst_regs[i], d, r);
			chk(d, 32'h0);
		end
		rd(5'h18, d, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		$display("test reset values done");

		wr(ADDR_CTRL, 32'h0000000d);
		rx(9'h15a);
		rd(ADDR_STATUS, d, r);
		chk(d, 32'h3);
		rd(ADDR_DATA, d, r);
		chk(d, 32'h15a);
		rx(9'h0a5);
		rd(ADDR_STATUS, d, r);
		chk(d, 32'h7);
		rd(ADDR_DATA, d, r);
		chk(d, 32'h15a);
		wr(ADDR_STATUS, 32'hd);
		rd(ADDR_STATUS, d, r);
		chk(d, 32'h2);
		$display("test load and loss done");

		wr(ADDR_IMASK, 32'h1);
		rx(9'h0c3);
		repeat (2) @(posedge clk_sys_i);
		chk({31'h0, irq_o}, 32'h1);
		wr(ADDR_IMASK, 32'h0);
		repeat (2) @(posedge clk_sys_i);
		chk({31'h0, irq_o}, 32'h0);
		wr(ADDR_IMASK, 32'h1);
		repeat (2) @(posedge clk_sys_i);
		chk({31'h0, irq_o}, 32'h1);
		wr(ADDR_STATUS, 32'h1);
		repeat (2) @(posedge clk_sys_i);
		chk({31'h0, irq_o}, 32'h0);
		wr(ADDR_IMASK, 32'h0);
		$display("test interrupt done");

		nbrx_master_model_inst.glitch(4);
		repeat (24) @(posedge clk_sys_i);
		rd(ADDR_STATUS, d, r);
		chk(d, 32'h8);
		rx(9'h1a5);
		rd(ADDR_STATUS, d, r);
		chk(d, 32'hb);
		wr(ADDR_STATUS, 32'hd);
		$display("test false start done");

		// Filter on in every mode, addresses around mask edges
		foreach (cases[i]) begin
			wr(ADDR_CTRL, {24'h0, 4'h0, cases[i].md, 2'h3});
			wr(ADDR_SLAVE_ADDR_REG, {24'h0, cases[i].sa});
			wr(ADDR_SMASK, {24'h0, cases[i].mk});
			rx(cases[i].fr);
			rd(ADDR_STATUS, d, r);
			chk({31'h0, d[0]}, {31'h0, cases[i].ok});
			if (cases[i].ok) begin
				rd(ADDR_DATA, d, r);
				chk({24'h0, d[7:0]}, {24'h0, cases[i].fr[7:0]});
			end
			wr(ADDR_STATUS, 32'hd);
		end
		$display("test filtering done");
		give_verdict();
	end
endmodule : nbrx_rx_tb
